// ### hw/ffrc_debounce.sv
// Persistence filter for one fault condition
`timescale 1ns/1ps
`default_nettype none
module ffrc_debounce #(
  parameter int CW = 28
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cond_i,
  input wire logic deb_en_i,
  input wire logic [CW-1:0] limit_i,
  output logic flag_o
);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic flag;
  } ffrc_deb_state_t;

  ffrc_deb_state_t q;
  ffrc_deb_state_t n;

  always_comb
  begin
    n = q;
    if (!cond_i)
    begin
      // Any drop restarts the interval
      n.cnt = '0;
      n.flag = 1'b0;
    end
    else if (!deb_en_i)
    begin
      n.flag = 1'b1;
    end
    else if (!q.flag)
    begin
      // A zero limit behaves as one cycle
      if (CW'(q.cnt + 1'b1) >= limit_i)
      begin
        n.flag = 1'b1;
      end
      else
      begin
        n.cnt = CW'(q.cnt + 1'b1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= n;
    end
  end

  assign flag_o = q.flag;

endmodule
`default_nettype wire

// ### hw/ffrc_top.sv
// Fault flag configuration registers, filtering and supply response sequencing
`timescale 1ns/1ps
`default_nettype none
module ffrc_top #(
  parameter int DEB_OCP_CYC = ffrc_pkg::DEB_OCP_CYC,
  parameter int DEB_OT_CYC = ffrc_pkg::DEB_OT_CYC,
  parameter int DEB_REV_CYC = ffrc_pkg::DEB_REV_CYC,
  parameter int DEB_LOCAL_OV_CYC = ffrc_pkg::DEB_LOCAL_OV_CYC,
  parameter int DEB_DEFAULT_CYC = ffrc_pkg::DEB_DEFAULT_CYC,
  parameter int OV_DEB_CYC = ffrc_pkg::OV_DEB_CYC,
  parameter int FAST_OV_DEB_CYC = ffrc_pkg::FAST_OV_DEB_CYC,
  parameter int RETRY_CYC = ffrc_pkg::RETRY_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic [11:0] FAULT_RAW_I,
  input wire logic SUPPLY_OV_RAW_I,
  input wire logic CORE_RAIL_OV_RAW_I,
  input wire logic FAST_LOCAL_OV_RAW_I,
  input wire logic POWER_ON_REQUEST_I,
  input wire logic SOFTSTART_DONE_I,
  input wire logic RELOAD_DONE_I,
  output logic SUPPLY_EN_O,
  output logic MAIN_PWM_EN_O,
  output logic AUXILIARY_PWM_OUTPUT_EN_O,
  output logic PWM_IMMEDIATE_OFF_O,
  output logic ORING_SWITCH_EN_O,
  output logic RELOAD_REQ_O,
  output logic [14:0] FAULT_ACTIVE_O
);

  localparam int CW = ffrc_pkg::CW;
  localparam int NS = 16;
  localparam int PON_BIT = 15;

  // Gray on every arc except reload -> run and retry -> latched
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_RETRY = 2'b01,
    ST_RELOAD = 2'b11,
    ST_LATCHED = 2'b10
  } ffrc_state_t;

  typedef struct packed {
    logic [ffrc_pkg::NUM_REGS-1:0][7:0] regs;
    logic [NS-1:0] sync1;
    logic [NS-1:0] sync2;
    logic pon_prev;
    ffrc_state_t state;
    logic [CW-1:0] timer;
    logic reload_pending;
    logic [7:0] rdata;
    logic supply_en;
    logic main_pwm_en;
    logic aux_en;
    logic fast_off;
    logic oring_en;
    logic reload_req;
    logic [ffrc_pkg::NUM_ALL-1:0] active;
  } ffrc_top_state_t;

  ffrc_top_state_t q;
  ffrc_top_state_t n;

  logic [ffrc_pkg::NUM_ALL-1:0] deb_flag;
  logic [ffrc_pkg::NUM_ALL-1:0] deb_en;
  logic [ffrc_pkg::NUM_ALL-1:0][CW-1:0] deb_limit;
  logic [ffrc_pkg::NUM_ALL-1:0] cond;

  // Returns {hit, index}; unmapped addresses miss
  function automatic logic [4:0] reg_index(input logic [7:0] addr);
    logic [4:0] r;
    r = 5'h00;
    unique case (addr)
      ffrc_pkg::A_PRIMARY_CURRENT: r = 5'h10;
      ffrc_pkg::A_SECONDARY_LOAD: r = 5'h11;
      ffrc_pkg::A_LOCAL_EXT: r = 5'h12;
      ffrc_pkg::A_TEMP_UNDERVOLT: r = 5'h13;
      ffrc_pkg::A_REVERSE_CONT: r = 5'h14;
      ffrc_pkg::A_SHARING_LINE: r = 5'h15;
      ffrc_pkg::A_DEBOUNCE_RESTART: r = {1'b1, ffrc_pkg::I_DEBOUNCE_RESTART};
      ffrc_pkg::A_SOFTSTART_BLANK: r = {1'b1, ffrc_pkg::I_SOFTSTART_BLANK};
      ffrc_pkg::A_AUX_PWM_SHUTDOWN: r = {1'b1, ffrc_pkg::I_AUX_PWM_SHUTDOWN};
      ffrc_pkg::A_FAST_OV_DEBOUNCE: r = {1'b1, ffrc_pkg::I_FAST_OV_DEBOUNCE};
      default: r = 5'h00;
    endcase
    return r;
  endfunction

  // Even flags sit in the upper half of their byte
  function automatic logic [2:0] flag_action(input logic [7:0] cfg, input logic upper);
    logic [2:0] a;
    a = upper ? cfg[ffrc_pkg::ACT_HI_LSB +: 3] : cfg[ffrc_pkg::ACT_LO_LSB +: 3];
    return a;
  endfunction

  function automatic logic flag_timing(input logic [7:0] cfg, input logic upper);
    logic t;
    t = upper ? cfg[ffrc_pkg::TIM_HI_BIT] : cfg[ffrc_pkg::TIM_LO_BIT];
    return t;
  endfunction

  logic [7:0] deb_restart;
  logic [7:0] blank_mask;
  logic [7:0] aux_cfg;
  logic [7:0] fast_cfg;
  logic [2:0] ocp_sel;
  logic [2:0] retry_sel;
  logic [2:0] fast_sel;
  logic [CW-1:0] retry_limit;

  assign deb_restart = q.regs[ffrc_pkg::I_DEBOUNCE_RESTART];
  assign blank_mask = q.regs[ffrc_pkg::I_SOFTSTART_BLANK];
  assign aux_cfg = q.regs[ffrc_pkg::I_AUX_PWM_SHUTDOWN];
  assign fast_cfg = q.regs[ffrc_pkg::I_FAST_OV_DEBOUNCE];
  assign ocp_sel = deb_restart[ffrc_pkg::OCP_DEB_LSB +: 3];
  assign retry_sel = {1'b0, deb_restart[ffrc_pkg::RETRY_SEL_LSB +: 2]};
  assign fast_sel = {1'b0, fast_cfg[ffrc_pkg::FAST_OV_SEL_LSB +: 2]};
  assign retry_limit = ffrc_pkg::scale_sel(CW'(RETRY_CYC), retry_sel,
                                           ffrc_pkg::SEL2_TOP);

  // Filter setup for every flag
  always_comb
  begin
    cond = q.sync2[ffrc_pkg::NUM_ALL-1:0];
    for (int k = 0; k < ffrc_pkg::NUM_FLAGS; k++)
    begin
      deb_en[k] = flag_timing(q.regs[k/2], ((k % 2) == 0));
      deb_limit[k] = CW'(DEB_DEFAULT_CYC);
    end
    deb_limit[ffrc_pkg::F_ACC_OCP_PRI] = ffrc_pkg::scale_sel(CW'(DEB_OCP_CYC), ocp_sel,
                                                             ffrc_pkg::OCP_SEL_TOP);
    deb_limit[ffrc_pkg::F_ACC_OCP_SEC] = deb_limit[ffrc_pkg::F_ACC_OCP_PRI];
    deb_limit[ffrc_pkg::F_OVERTEMP] = CW'(DEB_OT_CYC);
    deb_limit[ffrc_pkg::F_REVERSE] = CW'(DEB_REV_CYC);
    deb_limit[ffrc_pkg::F_LOCAL_OV] = CW'(DEB_LOCAL_OV_CYC);
    deb_en[ffrc_pkg::F_SUPPLY_OV] = deb_restart[ffrc_pkg::OV_TIMING_BIT];
    deb_en[ffrc_pkg::F_CORE_OV] = deb_restart[ffrc_pkg::OV_TIMING_BIT];
    deb_limit[ffrc_pkg::F_SUPPLY_OV] = CW'(OV_DEB_CYC);
    deb_limit[ffrc_pkg::F_CORE_OV] = CW'(OV_DEB_CYC);
    deb_en[ffrc_pkg::F_FAST_LOCAL_OV] = 1'b1;
    deb_limit[ffrc_pkg::F_FAST_LOCAL_OV] = ffrc_pkg::scale_sel(CW'(FAST_OV_DEB_CYC), fast_sel,
                                                               ffrc_pkg::SEL2_TOP);
  end

  for (genvar g = 0; g < ffrc_pkg::NUM_ALL; g++)
  begin : g_deb
    ffrc_debounce #(
      .CW(CW)
    ) u_deb (
      .clk_i(REF_CLK_I),
      .rst_n_i(RST_N_I),
      .cond_i(cond[g]),
      .deb_en_i(deb_en[g]),
      .limit_i(deb_limit[g]),
      .flag_o(deb_flag[g])
    );
  end

  // Response decode and sequencing
  logic [ffrc_pkg::NUM_ALL-1:0] eff;
  logic retry_hit;
  logic latch_hit;
  logic oring_hit;
  logic pwm_hit;
  logic ov_hit;
  logic pon_rise;
  logic [4:0] widx;
  logic [4:0] ridx;
  logic supply_on;
  logic [2:0] act;

  always_comb
  begin
    eff = '0;
    retry_hit = 1'b0;
    latch_hit = 1'b0;
    oring_hit = 1'b0;
    pwm_hit = 1'b0;
    act = 3'h0;
    for (int k = 0; k < ffrc_pkg::NUM_FLAGS; k++)
    begin
      eff[k] = deb_flag[k];
      // Blanking covers only the low flags, and only until the ramp ends
      if (k < ffrc_pkg::NUM_BLANK && blank_mask[k] && !SOFTSTART_DONE_I)
      begin
        eff[k] = 1'b0;
      end
    end
    // Flags past the mask range cannot be blanked
    eff[ffrc_pkg::F_SUPPLY_OV] = deb_flag[ffrc_pkg::F_SUPPLY_OV]
                                 & ~deb_restart[ffrc_pkg::OV_IGNORE_BIT];
    eff[ffrc_pkg::F_CORE_OV] = deb_flag[ffrc_pkg::F_CORE_OV]
                               & ~deb_restart[ffrc_pkg::OV_IGNORE_BIT];
    eff[ffrc_pkg::F_FAST_LOCAL_OV] = deb_flag[ffrc_pkg::F_FAST_LOCAL_OV];
    ov_hit = eff[ffrc_pkg::F_SUPPLY_OV] | eff[ffrc_pkg::F_CORE_OV];
    for (int k = 0; k <= ffrc_pkg::NUM_FLAGS; k++)
    begin
      // Slot NUM_FLAGS stands for the fast local overvoltage, sharing the accurate one's action
      if (k == ffrc_pkg::NUM_FLAGS)
      begin
        act = flag_action(q.regs[ffrc_pkg::F_LOCAL_OV/2], 1'b1);
      end
      else
      begin
        act = flag_action(q.regs[k/2], ((k % 2) == 0));
      end
      if ((k == ffrc_pkg::NUM_FLAGS) ? eff[ffrc_pkg::F_FAST_LOCAL_OV] : eff[k])
      begin
        unique case (act)
          ffrc_pkg::ACT_RETRY: retry_hit = 1'b1;
          ffrc_pkg::ACT_LATCH_OFF: latch_hit = 1'b1;
          ffrc_pkg::ACT_ORING_OFF: oring_hit = 1'b1;
          ffrc_pkg::ACT_PWM_OFF: pwm_hit = 1'b1;
          default: ; // Ignore and unused codes take no action
        endcase
      end
    end
    if (ov_hit)
    begin
      retry_hit = 1'b1;
    end
  end

  assign pon_rise = q.sync2[PON_BIT] & ~q.pon_prev;
  assign widx = reg_index(REG_ADDR_I);
  assign ridx = widx;

  always_comb
  begin
    n = q;
    n.sync1 = {POWER_ON_REQUEST_I, FAST_LOCAL_OV_RAW_I, CORE_RAIL_OV_RAW_I, SUPPLY_OV_RAW_I,
               FAULT_RAW_I};
    n.sync2 = q.sync1;
    n.pon_prev = q.sync2[PON_BIT];
    if (REG_WR_I && widx[4])
    begin
      n.regs[widx[3:0]] = REG_WDATA_I;
    end
    n.rdata = ridx[4] ? q.regs[ridx[3:0]] : 8'h00;
    unique case (q.state)
      ST_RUN:
      begin
        if (latch_hit)
        begin
          n.state = ST_LATCHED;
        end
        else if (retry_hit)
        begin
          n.state = ST_RETRY;
          n.timer = '0;
          n.reload_pending = ov_hit & deb_restart[ffrc_pkg::OV_RELOAD_BIT];
        end
      end
      ST_RETRY:
      begin
        if (latch_hit)
        begin
          n.state = ST_LATCHED;
        end
        else if (CW'(q.timer + 1'b1) >= retry_limit)
        begin
          n.state = q.reload_pending ? ST_RELOAD : ST_RUN;
        end
        else
        begin
          n.timer = CW'(q.timer + 1'b1);
        end
      end
      ST_RELOAD:
      begin
        // Supply stays off until the nonvolatile copy is back
        if (RELOAD_DONE_I)
        begin
          n.state = ST_RUN;
          n.reload_pending = 1'b0;
        end
      end
      ST_LATCHED:
      begin
        if (pon_rise)
        begin
          n.state = ST_RUN;
        end
      end
    endcase
    supply_on = (n.state == ST_RUN) && q.sync2[PON_BIT];
    n.supply_en = supply_on;
    n.main_pwm_en = supply_on & ~pwm_hit;
    n.aux_en = supply_on;
    // Gradual shutdown is the PWM stage's own business when the bit is clear
    n.fast_off = ~n.main_pwm_en & aux_cfg[ffrc_pkg::AUX_FAST_OFF_BIT];
    n.oring_en = supply_on & ~oring_hit;
    n.reload_req = (n.state == ST_RELOAD);
    n.active = eff;
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      q <= '0;
    end
    else
    begin
      q <= n;
    end
  end

  assign REG_RDATA_O = q.rdata;
  assign SUPPLY_EN_O = q.supply_en;
  assign MAIN_PWM_EN_O = q.main_pwm_en;
  assign AUXILIARY_PWM_OUTPUT_EN_O = q.aux_en;
  assign PWM_IMMEDIATE_OFF_O = q.fast_off;
  assign ORING_SWITCH_EN_O = q.oring_en;
  assign RELOAD_REQ_O = q.reload_req;
  assign FAULT_ACTIVE_O = q.active;

endmodule
`default_nettype wire

// ### pkg/ffrc_pkg.sv
// Constants, types and helpers for the fault flag response block
// Function
// - Every protection flag has a three-bit action field in one half of its byte.
// - Every protection flag has a timing bit at bit 7 or bit 3 choosing immediate or debounced.
// - Primary overcurrent pairs fill one byte, secondary current and load overvoltage the next.
// - Local overvoltage and external flag fill a byte, temperature and undervoltage the next.
// - Actions: ignore, retry, latch off, oring switch off, or all but the auxiliary PWM off.
// - Debounced flags set only after the condition lasts 260 ms, 100 ms, 10 ms or the like.
// - One three-bit field sets the debounce shared by both accurate overcurrent flags.
// - A timing bit selects a 2 us debounce for supply or core overvoltage before shutdown.
// - The supply/core overvoltage ignore bit stops any action on those two flags.
// - The reload bit refetches nonvolatile configuration before an overvoltage restart.
// - A two-bit field in its own register sets the fast local overvoltage debounce, up to 8 us.
// - A two-bit field sets the wait, such as 1 s, before a retry re-enables the supply.
// - The auxiliary immediate-shutdown bit turns the other PWMs off at once, not gradually.
// - Each bit of an eight-bit mask blanks its flag until the soft-start ramp is done.
package ffrc_pkg;

  localparam int CLK_PERIOD_NS = 8;
  localparam int CW = 28;

  // Flag indices; pairs share a byte, even index in the upper half
  localparam int NUM_FLAGS = 12;
  localparam int NUM_ALL = 15;
  localparam int F_FAST_OCP = 0;
  localparam int F_ACC_OCP_PRI = 1;
  localparam int F_ACC_OCP_SEC = 2;
  localparam int F_LOAD_OV = 3;
  localparam int F_LOCAL_OV = 4;
  localparam int F_EXTERNAL = 5;
  localparam int F_OVERTEMP = 6;
  localparam int F_UNDERVOLT = 7;
  localparam int F_REVERSE = 8;
  localparam int F_CONTINUITY = 9;
  localparam int F_SHARE = 10;
  localparam int F_LINE = 11;
  localparam int F_SUPPLY_OV = 12;
  localparam int F_CORE_OV = 13;
  localparam int F_FAST_LOCAL_OV = 14;
  localparam int NUM_BLANK = 8;

  // Register offsets
  localparam int NUM_REGS = 10;
  localparam logic [7:0] A_PRIMARY_CURRENT = 8'h08;
  localparam logic [7:0] A_SECONDARY_LOAD = 8'h09;
  localparam logic [7:0] A_LOCAL_EXT = 8'h0A;
  localparam logic [7:0] A_TEMP_UNDERVOLT = 8'h0B;
  localparam logic [7:0] A_REVERSE_CONT = 8'h0C;
  localparam logic [7:0] A_SHARING_LINE = 8'h0D;
  localparam logic [7:0] A_DEBOUNCE_RESTART = 8'h0E;
  localparam logic [7:0] A_SOFTSTART_BLANK = 8'h0F;
  localparam logic [7:0] A_AUX_PWM_SHUTDOWN = 8'h34;
  localparam logic [7:0] A_FAST_OV_DEBOUNCE = 8'h37;
  localparam logic [3:0] I_DEBOUNCE_RESTART = 4'h6;
  localparam logic [3:0] I_SOFTSTART_BLANK = 4'h7;
  localparam logic [3:0] I_AUX_PWM_SHUTDOWN = 4'h8;
  localparam logic [3:0] I_FAST_OV_DEBOUNCE = 4'h9;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Field positions
  localparam int TIM_HI_BIT = 7;
  localparam int ACT_HI_LSB = 4;
  localparam int TIM_LO_BIT = 3;
  localparam int ACT_LO_LSB = 0;
  localparam int OV_IGNORE_BIT = 7;
  localparam int OV_RELOAD_BIT = 6;
  localparam int OV_TIMING_BIT = 5;
  localparam int OCP_DEB_LSB = 2;
  localparam int RETRY_SEL_LSB = 0;
  localparam int AUX_FAST_OFF_BIT = 7;
  localparam int FAST_OV_SEL_LSB = 6;
  localparam logic [2:0] OCP_SEL_TOP = 3'h7;
  localparam logic [2:0] SEL2_TOP = 3'h3;

  // Action codes
  typedef enum logic [2:0] {
    ACT_IGNORE = 3'h0,
    ACT_RETRY = 3'h1,
    ACT_LATCH_OFF = 3'h2,
    ACT_ORING_OFF = 3'h3,
    ACT_PWM_OFF = 3'h4
  } ffrc_action_t;

  // Times as specified and their cycle counts
  localparam int DEB_OCP_MS = 260;
  localparam int DEB_OT_MS = 100;
  localparam int DEB_REV_MS = 10;
  localparam int DEB_LOCAL_OV_MS = 2;
  localparam int DEB_DEFAULT_MS = 10;
  localparam int OV_DEB_US = 2;
  localparam int FAST_OV_DEB_US = 8;
  localparam int RETRY_S = 1;
  localparam int DEB_OCP_CYC = (DEB_OCP_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_OT_CYC = (DEB_OT_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_REV_CYC = (DEB_REV_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_LOCAL_OV_CYC =
    (DEB_LOCAL_OV_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_DEFAULT_CYC = (DEB_DEFAULT_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OV_DEB_CYC = (OV_DEB_US * 1_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FAST_OV_DEB_CYC = (FAST_OV_DEB_US * 1_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_CYC = (RETRY_S * 1_000_000_000) / CLK_PERIOD_NS;

  // Top code of a selector gives the full base, each step down halves it
  function automatic logic [CW-1:0] scale_sel(input logic [CW-1:0] base, input logic [2:0] sel,
                                              input logic [2:0] top);
    logic [2:0] sh;
    sh = top - sel;
    return base >> sh;
  endfunction

endpackage

// ### verif/ffrc_plant.sv
// Power stage model: soft-start ramp and configuration reload answer
`timescale 1ns/1ps
`default_nettype none
module ffrc_plant #(
  parameter int RAMP_CYC = 12,
  parameter int LOAD_CYC = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic supply_en_i,
  input wire logic reload_req_i,
  input wire logic hold_ramp_i,
  output logic softstart_done_o,
  output logic reload_done_o
);
  int ramp_q;
  int load_q;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ramp_q <= 0;
      load_q <= 0;
    end
    else
    begin
      ramp_q <= supply_en_i ? ramp_q + int'(ramp_q < RAMP_CYC) : 0;
      load_q <= reload_req_i ? load_q + int'(load_q < LOAD_CYC) : 0;
    end
  end
  // Ramp restarts whenever the supply drops; the bench may stall it
  assign softstart_done_o = ramp_q == RAMP_CYC && !hold_ramp_i;
  assign reload_done_o = load_q == LOAD_CYC;
endmodule
`default_nettype wire

// ### verif/ffrc_properties.sv
// Port-level checks for the fault flag response block
`timescale 1ns/1ps
`default_nettype none
module ffrc_properties #(
  parameter int DEB_OCP_CYC = 64
) (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic [11:0] FAULT_RAW_I,
  input wire logic SOFTSTART_DONE_I,
  input wire logic SUPPLY_EN_O,
  input wire logic MAIN_PWM_EN_O,
  input wire logic PWM_IMMEDIATE_OFF_O,
  input wire logic ORING_SWITCH_EN_O,
  input wire logic RELOAD_REQ_O,
  input wire logic [14:0] FAULT_ACTIVE_O
);
  logic [7:0] c08_q, c0e_q, c0f_q, c34_q;
  logic [15:0] run_q;
  logic mapped;
  int lim;
  always_comb mapped = REG_ADDR_I[7:3] == 5'h01 || REG_ADDR_I == 8'h34 || REG_ADDR_I == 8'h37;
  always_comb lim = DEB_OCP_CYC >> (7 - int'(c0e_q[4:2]));
  // Shadow copies of the registers the checks depend on
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      c08_q <= 8'h00;
      c0e_q <= 8'h00;
      c0f_q <= 8'h00;
      c34_q <= 8'h00;
      run_q <= 16'h0000;
    end
    else
    begin
      run_q <= FAULT_RAW_I[1] ? run_q + 16'h0001 : 16'h0000;
      if (REG_WR_I && REG_ADDR_I == 8'h08)
        c08_q <= REG_WDATA_I;
      if (REG_WR_I && REG_ADDR_I == 8'h0E)
        c0e_q <= REG_WDATA_I;
      if (REG_WR_I && REG_ADDR_I == 8'h0F)
        c0f_q <= REG_WDATA_I;
      if (REG_WR_I && REG_ADDR_I == 8'h34)
        c34_q <= REG_WDATA_I;
    end
  end
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  rd_unmapped_a: assert property (!mapped |=> REG_RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  wr_read_back_a: assert property (REG_WR_I && mapped ##1 !REG_WR_I && $stable(REG_ADDR_I)
    |=> REG_RDATA_O == $past(REG_WDATA_I, 2)) else $error("read back differs");
  fast_set_a: assert property ((FAULT_RAW_I[0] && !c08_q[7] && c08_q[6:4] == 3'h3 && !c0f_q[0])
    [*6] |-> FAULT_ACTIVE_O[0]) else $error("immediate flag late");
  fast_clr_a: assert property ((!FAULT_RAW_I[0]) [*6] |-> !FAULT_ACTIVE_O[0])
    else $error("flag stays after drop");
  deb_min_a: assert property ($rose(FAULT_ACTIVE_O[1]) && c08_q[3] |-> run_q >= lim)
    else $error("debounced flag early");
  deb_max_a: assert property (run_q >= lim + 3 && c08_q[3] && c08_q[2:0] == 3'h1 && !c0f_q[1]
    |-> FAULT_ACTIVE_O[1]) else $error("debounced flag late");
  ov_ignore_a: assert property (c0e_q[7] && $past(c0e_q[7]) |-> FAULT_ACTIVE_O[13:12] == 2'b00)
    else $error("ignored ov flag set");
  blank_mask_a: assert property ((!SOFTSTART_DONE_I && c0f_q[0]) [*3] |-> !FAULT_ACTIVE_O[0])
    else $error("blanked flag set");
  retry_off_a: assert property ($rose(FAULT_ACTIVE_O[1]) && c08_q[2:0] == 3'h1
    |-> !SUPPLY_EN_O && !MAIN_PWM_EN_O) else $error("retry did not disable");
  oring_off_a: assert property (FAULT_ACTIVE_O[0] && c08_q[6:4] == 3'h3 && $stable(c08_q)
    |-> !ORING_SWITCH_EN_O) else $error("oring switch left on");
  pwm_imm_a: assert property (PWM_IMMEDIATE_OFF_O |-> !MAIN_PWM_EN_O && $past(c34_q[7]))
    else $error("immediate off without cause");
  cover property ($fell(SUPPLY_EN_O));
  cover property ($rose(RELOAD_REQ_O));
  cover property ($rose(PWM_IMMEDIATE_OFF_O));
endmodule
`default_nettype wire

// ### verif/tb_ffrc_top.sv
// Self-checking testbench for the fault flag response block
`timescale 1ns/1ps
`default_nettype none
module tb_ffrc_top;
  localparam int OVERCURRENT_TRIP = 64;
  localparam int OT = 40;
  localparam int RTY = 64;
  localparam int OVD = 8;
  localparam int FOV = 16;
  localparam int SUP = 15;
  localparam int RLQ = 16;
  localparam logic [7:0] REGS [10] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E,
    8'h0F, 8'h34, 8'h37};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [11:0] raw = 12'h000;
  logic sov = 1'b0;
  logic cov = 1'b0;
  logic fov = 1'b0;
  logic pon = 1'b0;
  logic hold = 1'b0;
  logic [7:0] rdata;
  logic ss_done, rl_done, sup, mpwm, aux, imm, oring, rl_req;
  logic [14:0] act;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  ffrc_top #(.DEB_OCP_CYC(OVERCURRENT_TRIP), .DEB_OT_CYC(OT), .DEB_REV_CYC(20), .DEB_LOCAL_OV_CYC(12),
    .DEB_DEFAULT_CYC(16), .OV_DEB_CYC(OVD), .FAST_OV_DEB_CYC(FOV), .RETRY_CYC(RTY)) i_ffrc_top (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .REG_WR_I(reg_wr), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .FAULT_RAW_I(raw), .SUPPLY_OV_RAW_I(sov),
    .CORE_RAIL_OV_RAW_I(cov), .FAST_LOCAL_OV_RAW_I(fov), .POWER_ON_REQUEST_I(pon),
    .SOFTSTART_DONE_I(ss_done), .RELOAD_DONE_I(rl_done), .SUPPLY_EN_O(sup),
    .MAIN_PWM_EN_O(mpwm), .AUXILIARY_PWM_OUTPUT_EN_O(aux), .PWM_IMMEDIATE_OFF_O(imm),
    .ORING_SWITCH_EN_O(oring), .RELOAD_REQ_O(rl_req), .FAULT_ACTIVE_O(act));
  ffrc_plant i_ffrc_plant (.clk_i(clk), .rst_n_i(rst_n), .supply_en_i(sup),
    .reload_req_i(rl_req), .hold_ramp_i(hold), .softstart_done_o(ss_done),
    .reload_done_o(rl_done));
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_byte({7'h00, got}, {7'h00, exp}, what);
  endtask
  task automatic chk_cnt(input int n, input int lo, input int hi, input string what);
    check_count++;
    if (n < lo || n > hi)
    begin
      bad_count++;
      $display("Error at %0t: %s took %0d cycles", $time, what, n);
    end
  endtask
  function automatic logic pick(input int sel);
    return sel < 15 ? act[sel] : sel == SUP ? sup : rl_req;
  endfunction
  // Bounded wait; the count returned is the cycles it took
  task automatic wait_out(input int sel, input logic val, input int max, output int n);
    n = 0;
    while (pick(sel) !== val && n < max)
    begin
      step();
      n++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step();
    reg_wr = 1'b1;
    addr = a;
    wdata = d;
    step();
    reg_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    step();
    addr = a;
    step(2);
    chk_byte(rdata, exp, "read data");
  endtask
  task automatic t_regs();
    foreach (REGS[i])
      rd_chk(REGS[i], 8'h00);
    foreach (REGS[i])
    begin
      wr(REGS[i], 8'hA5 ^ REGS[i]);
      rd_chk(REGS[i], 8'hA5 ^ REGS[i]);
      wr(REGS[i], 8'h00);
    end
    wr(8'h10, 8'hFF);
    rd_chk(8'h10, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_imm();
    int n;
    wr(8'h08, 8'h30);
    raw[0] = 1'b1;
    wait_out(0, 1'b1, 20, n);
    chk_cnt(n, 3, 5, "immediate flag");
    chk_bit(oring, 1'b0, "oring off");
    chk_bit(sup, 1'b1, "supply kept");
    step(2);
    raw[0] = 1'b0;
    wait_out(0, 1'b0, 20, n);
    chk_bit(act[0], 1'b0, "flag dropped");
    wr(8'h0F, 8'h01);
    hold = 1'b1;
    raw[0] = 1'b1;
    step(12);
    chk_bit(act[0], 1'b0, "blanked flag");
    chk_bit(oring, 1'b1, "blanked oring");
    hold = 1'b0;
    wait_out(0, 1'b1, 8, n);
    chk_bit(act[0], 1'b1, "flag after ramp");
    raw[0] = 1'b0;
    wr(8'h0F, 8'h00);
    wr(8'h08, 8'h00);
    $display("t_imm done");
  endtask
  task automatic t_deb();
    int n;
    wr(8'h0E, 8'h11);
    wr(8'h08, 8'h09);
    raw[1] = 1'b1;
    step(6);
    raw[1] = 1'b0;
    step(2);
    raw[1] = 1'b1;
    wait_out(1, 1'b1, 40, n);
    chk_cnt(n, OVERCURRENT_TRIP / 8 + 2, OVERCURRENT_TRIP / 8 + 4, "shared debounce");
    chk_bit(sup, 1'b0, "retry off");
    raw[1] = 1'b0;
    wait_out(SUP, 1'b1, 60, n);
    chk_cnt(n, RTY / 4 - 2, RTY / 4 + 6, "retry delay");
    wr(8'h08, 8'h00);
    $display("t_deb done");
  endtask
  task automatic t_latch();
    int n;
    wr(8'h0B, 8'hA0);
    raw[6] = 1'b1;
    wait_out(6, 1'b1, 60, n);
    chk_cnt(n, OT + 2, OT + 4, "overtemp debounce");
    raw[6] = 1'b0;
    step(RTY + 10);
    chk_bit(sup, 1'b0, "latched off");
    pon = 1'b0;
    step(4);
    pon = 1'b1;
    wait_out(SUP, 1'b1, 10, n);
    chk_bit(sup, 1'b1, "power on request");
    wr(8'h0B, 8'h00);
    $display("t_latch done");
  endtask
  task automatic t_pwm();
    int n;
    wr(8'h34, 8'h80);
    wr(8'h0C, 8'h40);
    raw[8] = 1'b1;
    wait_out(8, 1'b1, 20, n);
    chk_bit(mpwm, 1'b0, "main pwm off");
    chk_bit(aux, 1'b1, "aux kept");
    chk_bit(imm, 1'b1, "immediate off");
    raw[8] = 1'b0;
    wait_out(8, 1'b0, 20, n);
    chk_bit(mpwm, 1'b1, "main pwm back");
    wr(8'h34, 8'h00);
    wr(8'h0C, 8'h00);
    $display("t_pwm done");
  endtask
  task automatic t_ov();
    int n;
    wr(8'h0E, 8'h71);
    sov = 1'b1;
    wait_out(12, 1'b1, 30, n);
    chk_cnt(n, OVD + 2, OVD + 4, "supply ov debounce");
    chk_bit(sup, 1'b0, "ov shutdown");
    sov = 1'b0;
    wait_out(RLQ, 1'b1, 40, n);
    chk_bit(rl_req, 1'b1, "reload asked");
    chk_bit(sup, 1'b0, "off during reload");
    wait_out(SUP, 1'b1, 20, n);
    chk_bit(rl_req, 1'b0, "reload finished");
    wr(8'h0E, 8'hF1);
    cov = 1'b1;
    step(20);
    chk_bit(act[13], 1'b0, "core ov ignored");
    chk_bit(sup, 1'b1, "no ov action");
    cov = 1'b0;
    // Let the filtered flag clear before unmasking it
    step(4);
    wr(8'h0E, 8'h11);
    $display("t_ov done");
  endtask
  task automatic t_fov();
    int n;
    wr(8'h37, 8'h40);
    wr(8'h0A, 8'h10);
    fov = 1'b1;
    wait_out(14, 1'b1, 30, n);
    chk_cnt(n, FOV / 4 + 2, FOV / 4 + 4, "fast ov debounce");
    chk_bit(sup, 1'b0, "fast ov action");
    fov = 1'b0;
    wait_out(SUP, 1'b1, 60, n);
    chk_bit(sup, 1'b1, "retry after fast ov");
    wr(8'h37, 8'h00);
    wr(8'h0A, 8'h00);
    $display("t_fov done");
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      $display("Error at %0t: run timed out", $time);
      complete_run();
    end
  end
  initial
  begin
    int n;
    step(3);
    rst_n = 1'b1;
    pon = 1'b1;
    wait_out(SUP, 1'b1, 10, n);
    chk_bit(sup, 1'b1, "power up");
    step(16);
    t_regs();
    t_imm();
    t_deb();
    t_latch();
    t_pwm();
    t_ov();
    t_fov();
    complete_run();
  end
endmodule
bind ffrc_top ffrc_properties #(.DEB_OCP_CYC(DEB_OCP_CYC)) i_ffrc_properties (.REF_CLK_I,
  .RST_N_I, .REG_WR_I, .REG_ADDR_I, .REG_WDATA_I, .REG_RDATA_O, .FAULT_RAW_I,
  .SOFTSTART_DONE_I, .SUPPLY_EN_O, .MAIN_PWM_EN_O, .PWM_IMMEDIATE_OFF_O, .ORING_SWITCH_EN_O,
  .RELOAD_REQ_O, .FAULT_ACTIVE_O);
`default_nettype wire
